/* File: hw/input_remap_map.vh */
`ifndef INPUT_REMAP_MAP_VH
`define INPUT_REMAP_MAP_VH

// Register bus geometry
`define REG_ADDR_W          4
`define REG_DATA_W          16

// Register addresses
`define ADDR_LOCK_CONFIG    4'h0
`define ADDR_EXT_IRQ1_SEL   4'h1
`define ADDR_EXT_IRQ2_3_SEL 4'h2
`define ADDR_TIMER1_CK_SEL  4'h3
`define ADDR_CAPTURE1_SEL   4'h4
`define ADDR_CAPTURE2_SEL   4'h5
`define ADDR_CAPTURE3_SEL   4'h6
`define ADDR_CAPTURE4_SEL   4'h7
`define ADDR_CAPTURE5_SEL   4'h8
`define ADDR_CAPTURE6_SEL   4'h9
`define ADDR_UNLOCK_KEY     4'hA
`define ADDR_REMAP_STATUS   4'hB

// Field layout
`define LOCK_BIT            11
`define CODE_W              8
`define CODE_HI_MSB         15
`define CODE_HI_LSB         8
`define CODE_LO_MSB         7
`define CODE_LO_LSB         0
`define STATUS_ARMED_BIT    0
`define STATUS_BLOCKED_BIT  1
`define STATUS_LOCK_BIT     2

// Reset values
`define CODE_RESET          8'h00
`define DATA_ZERO           16'h0000

// Unlock sequence keys
`define UNLOCK_KEY_FIRST    16'h0055
`define UNLOCK_KEY_SECOND   16'h00AA

// Remappable pin set
`define REMAP_PIN_COUNT     32
`define REMAP_PIN_IDX_W     5
`define REMAP_PIN_LAST      9'h020
`define REMAP_CODE_BASE     9'h001
`define FIELD_COUNT         16

`endif

/* File: hw/remap_pin_select.v */
`timescale 1ns/100ps
`include "input_remap_map.vh"

module remap_pin_select (
  input  wire                          mclk,
  input  wire                          reset_n,
  input  wire [`CODE_W-1:0]            pin_code,
  input  wire [`REMAP_PIN_COUNT-1:0]   pin_level,
  output reg                           routed_level
);

  wire [8:0] pin_index;
  reg        next_routed_level;

  assign pin_index = {1'b0, pin_code} - `REMAP_CODE_BASE;

  always @* begin
    next_routed_level = 1'b0;
    // Code zero and codes past the pin set leave the input parked low
    if (pin_code != `CODE_RESET && {1'b0, pin_code} <= `REMAP_PIN_LAST) begin
      next_routed_level = pin_level[pin_index[`REMAP_PIN_IDX_W-1:0]];
    end
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      routed_level <= 1'b0;
    end else begin
      routed_level <= next_routed_level;
    end
  end

endmodule // remap_pin_select

/* File: hw/input_pin_remap_select.v */
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`include "input_remap_map.vh"

module input_pin_remap_select (
  input  wire                          mclk,
  input  wire                          reset_n,
  input  wire [`REG_ADDR_W-1:0]        reg_addr,
  input  wire [`REG_DATA_W-1:0]        reg_wdata,
  input  wire                          reg_write,
  input  wire                          reg_read,
  output reg  [`REG_DATA_W-1:0]        reg_rdata,
  input  wire [`REMAP_PIN_COUNT-1:0]   remappable_pin,
  output reg                           remap_lock,
  output wire                          ext_irq1_in,
  output wire                          ext_irq2_in,
  output wire                          ext_irq3_in,
  output wire                          timer1_clock_in,
  output wire                          capture1_in,
  output wire                          capture2_in,
  output wire                          capture3_in,
  output wire                          capture4_in,
  output wire                          capture5_in,
  output wire                          capture6_in,
  output wire                          unit1_timer_clock_in,
  output wire                          unit2_timer_clock_in,
  output wire                          unit3_timer_clock_in,
  output wire                          unit4_timer_clock_in,
  output wire                          unit5_timer_clock_in,
  output wire                          unit6_timer_clock_in
);

  localparam [1:0] UNLOCK_IDLE  = 2'b00;
  localparam [1:0] UNLOCK_FIRST = 2'b01;
  localparam [1:0] UNLOCK_ARMED = 2'b10;

  reg  [1:0]                        unlock_state;
  reg  [1:0]                        next_unlock_state;
  reg                               write_blocked;

  reg  [`CODE_W-1:0]                ext_irq1_pin_code;
  reg  [`CODE_W-1:0]                ext_irq2_pin_code;
  reg  [`CODE_W-1:0]                ext_irq3_pin_code;
  reg  [`CODE_W-1:0]                timer1_clock_pin_code;
  reg  [`CODE_W-1:0]                capture1_pin_code;
  reg  [`CODE_W-1:0]                capture2_pin_code;
  reg  [`CODE_W-1:0]                capture3_pin_code;
  reg  [`CODE_W-1:0]                capture4_pin_code;
  reg  [`CODE_W-1:0]                capture5_pin_code;
  reg  [`CODE_W-1:0]                capture6_pin_code;
  reg  [`CODE_W-1:0]                unit1_timer_clock_pin_code;
  reg  [`CODE_W-1:0]                unit2_timer_clock_pin_code;
  reg  [`CODE_W-1:0]                unit3_timer_clock_pin_code;
  reg  [`CODE_W-1:0]                unit4_timer_clock_pin_code;
  reg  [`CODE_W-1:0]                unit5_timer_clock_pin_code;
  reg  [`CODE_W-1:0]                unit6_timer_clock_pin_code;

  reg  [`REMAP_PIN_COUNT-1:0]       pin_meta;
  reg  [`REMAP_PIN_COUNT-1:0]       pin_sync;

  reg  [`REG_DATA_W-1:0]            next_reg_rdata;
  wire                              selector_addr;
  wire                              selector_write;
  wire                              lock_write;
  wire                              status_write;
  wire                              config_write;
  wire                              key_first_write;
  wire                              key_second_write;
  wire                              lock_armed;
  wire                              selector_refused;
  wire                              config_refused;
  wire                              write_refused;
  wire                              status_clear;
  wire [`FIELD_COUNT*`CODE_W-1:0]   field_codes;
  wire [`FIELD_COUNT-1:0]           routed;

  // Two stages before any logic sees a pin; only the second stage is read
  always @(posedge mclk) begin
    if (!reset_n) begin
      pin_meta <= {`REMAP_PIN_COUNT{1'b0}};
    end else begin
      pin_meta <= remappable_pin;
    end
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      pin_sync <= {`REMAP_PIN_COUNT{1'b0}};
    end else begin
      pin_sync <= pin_meta;
    end
  end

  assign selector_addr = (reg_addr >= `ADDR_EXT_IRQ1_SEL) && (reg_addr <= `ADDR_CAPTURE6_SEL);
  assign config_write = reg_write && (reg_addr == `ADDR_LOCK_CONFIG);
  assign key_first_write = reg_write && (reg_addr == `ADDR_UNLOCK_KEY) && (reg_wdata == `UNLOCK_KEY_FIRST);
  assign key_second_write = reg_write && (reg_addr == `ADDR_UNLOCK_KEY) && (reg_wdata == `UNLOCK_KEY_SECOND);
  // Arm lasts for exactly one following write
  assign lock_armed = (unlock_state == UNLOCK_ARMED);
  assign selector_write = reg_write && selector_addr && !remap_lock;
  assign lock_write = config_write && lock_armed;
  assign status_write = reg_write && (reg_addr == `ADDR_REMAP_STATUS);

  // Refusals only feed the sticky status flag; the stores never see them
  assign selector_refused = reg_write && selector_addr && remap_lock;
  assign config_refused = config_write && !lock_armed;
  assign write_refused = selector_refused || config_refused;
  assign status_clear = status_write && reg_wdata[`STATUS_BLOCKED_BIT];

  // Unlock sequence: first key, second key, then one write to the config register.
  // Any other write in between, except a repeat of the first key before the second, drops the sequence, so a stray store cannot arm it.
  always @* begin
    next_unlock_state = unlock_state;
    if (reg_write) begin
      case (unlock_state)
        UNLOCK_IDLE: begin
          if (key_first_write) begin
            next_unlock_state = UNLOCK_FIRST;
          end
        end
        UNLOCK_FIRST: begin
          if (key_second_write) begin
            next_unlock_state = UNLOCK_ARMED;
          end else if (key_first_write) begin
            next_unlock_state = UNLOCK_FIRST;
          end else begin
            next_unlock_state = UNLOCK_IDLE;
          end
        end
        UNLOCK_ARMED: begin
          next_unlock_state = UNLOCK_IDLE;
        end
        default: begin
          next_unlock_state = UNLOCK_IDLE;
        end
      endcase
    end
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      unlock_state <= UNLOCK_IDLE;
    end else begin
      unlock_state <= next_unlock_state;
    end
  end

  // Lock bit; only bit 11 of the written word is kept
  always @(posedge mclk) begin
    if (!reset_n) begin
      remap_lock <= 1'b0;
    end else if (lock_write) begin
      remap_lock <= reg_wdata[`LOCK_BIT];
    end
  end

  // Sticky record of a refused write; a new refusal beats the clear
  always @(posedge mclk) begin
    if (!reset_n) begin
      write_blocked <= 1'b0;
    end else if (write_refused) begin
      write_blocked <= 1'b1;
    end else if (status_clear) begin
      write_blocked <= 1'b0;
    end
  end

  // Selector fields; a refused write touches nothing
  always @(posedge mclk) begin
    if (!reset_n) begin
      ext_irq1_pin_code          <= `CODE_RESET;
      ext_irq2_pin_code          <= `CODE_RESET;
      ext_irq3_pin_code          <= `CODE_RESET;
      timer1_clock_pin_code      <= `CODE_RESET;
      capture1_pin_code          <= `CODE_RESET;
      capture2_pin_code          <= `CODE_RESET;
      capture3_pin_code          <= `CODE_RESET;
      capture4_pin_code          <= `CODE_RESET;
      capture5_pin_code          <= `CODE_RESET;
      capture6_pin_code          <= `CODE_RESET;
      unit1_timer_clock_pin_code <= `CODE_RESET;
      unit2_timer_clock_pin_code <= `CODE_RESET;
      unit3_timer_clock_pin_code <= `CODE_RESET;
      unit4_timer_clock_pin_code <= `CODE_RESET;
      unit5_timer_clock_pin_code <= `CODE_RESET;
      unit6_timer_clock_pin_code <= `CODE_RESET;
    end else if (selector_write) begin
      case (reg_addr)
        `ADDR_EXT_IRQ1_SEL: begin
          ext_irq1_pin_code <= reg_wdata[`CODE_HI_MSB:`CODE_HI_LSB];
        end
        `ADDR_EXT_IRQ2_3_SEL: begin
          ext_irq3_pin_code <= reg_wdata[`CODE_HI_MSB:`CODE_HI_LSB];
          ext_irq2_pin_code <= reg_wdata[`CODE_LO_MSB:`CODE_LO_LSB];
        end
        `ADDR_TIMER1_CK_SEL: begin
          timer1_clock_pin_code <= reg_wdata[`CODE_HI_MSB:`CODE_HI_LSB];
        end
        `ADDR_CAPTURE1_SEL: begin
          capture1_pin_code          <= reg_wdata[`CODE_HI_MSB:`CODE_HI_LSB];
          unit1_timer_clock_pin_code <= reg_wdata[`CODE_LO_MSB:`CODE_LO_LSB];
        end
        `ADDR_CAPTURE2_SEL: begin
          capture2_pin_code          <= reg_wdata[`CODE_HI_MSB:`CODE_HI_LSB];
          unit2_timer_clock_pin_code <= reg_wdata[`CODE_LO_MSB:`CODE_LO_LSB];
        end
        `ADDR_CAPTURE3_SEL: begin
          capture3_pin_code          <= reg_wdata[`CODE_HI_MSB:`CODE_HI_LSB];
          unit3_timer_clock_pin_code <= reg_wdata[`CODE_LO_MSB:`CODE_LO_LSB];
        end
        `ADDR_CAPTURE4_SEL: begin
          capture4_pin_code          <= reg_wdata[`CODE_HI_MSB:`CODE_HI_LSB];
          unit4_timer_clock_pin_code <= reg_wdata[`CODE_LO_MSB:`CODE_LO_LSB];
        end
        `ADDR_CAPTURE5_SEL: begin
          capture5_pin_code          <= reg_wdata[`CODE_HI_MSB:`CODE_HI_LSB];
          unit5_timer_clock_pin_code <= reg_wdata[`CODE_LO_MSB:`CODE_LO_LSB];
        end
        `ADDR_CAPTURE6_SEL: begin
          capture6_pin_code          <= reg_wdata[`CODE_HI_MSB:`CODE_HI_LSB];
          unit6_timer_clock_pin_code <= reg_wdata[`CODE_LO_MSB:`CODE_LO_LSB];
        end
        default: begin
          ext_irq1_pin_code <= ext_irq1_pin_code;
        end
      endcase
    end
  end

  // Read path; unimplemented halves and unmapped addresses give zero
  always @* begin
    next_reg_rdata = `DATA_ZERO;
    case (reg_addr)
      `ADDR_LOCK_CONFIG: begin
        next_reg_rdata[`LOCK_BIT] = remap_lock;
      end
      `ADDR_EXT_IRQ1_SEL: begin
        next_reg_rdata[`CODE_HI_MSB:`CODE_HI_LSB] = ext_irq1_pin_code;
      end
      `ADDR_EXT_IRQ2_3_SEL: begin
        next_reg_rdata = {ext_irq3_pin_code, ext_irq2_pin_code};
      end
      `ADDR_TIMER1_CK_SEL: begin
        next_reg_rdata[`CODE_HI_MSB:`CODE_HI_LSB] = timer1_clock_pin_code;
      end
      `ADDR_CAPTURE1_SEL: begin
        next_reg_rdata = {capture1_pin_code, unit1_timer_clock_pin_code};
      end
      `ADDR_CAPTURE2_SEL: begin
        next_reg_rdata = {capture2_pin_code, unit2_timer_clock_pin_code};
      end
      `ADDR_CAPTURE3_SEL: begin
        next_reg_rdata = {capture3_pin_code, unit3_timer_clock_pin_code};
      end
      `ADDR_CAPTURE4_SEL: begin
        next_reg_rdata = {capture4_pin_code, unit4_timer_clock_pin_code};
      end
      `ADDR_CAPTURE5_SEL: begin
        next_reg_rdata = {capture5_pin_code, unit5_timer_clock_pin_code};
      end
      `ADDR_CAPTURE6_SEL: begin
        next_reg_rdata = {capture6_pin_code, unit6_timer_clock_pin_code};
      end
      `ADDR_REMAP_STATUS: begin
        next_reg_rdata[`STATUS_ARMED_BIT]   = lock_armed;
        next_reg_rdata[`STATUS_BLOCKED_BIT] = write_blocked;
        next_reg_rdata[`STATUS_LOCK_BIT]    = remap_lock;
      end
      default: begin
        next_reg_rdata = `DATA_ZERO;
      end
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always @(posedge mclk) begin
    if (!reset_n) begin
      reg_rdata <= `DATA_ZERO;
    end else if (reg_read) begin
      reg_rdata <= next_reg_rdata;
    end else begin
      reg_rdata <= `DATA_ZERO;
    end
  end

  assign field_codes = {unit6_timer_clock_pin_code,
                        unit5_timer_clock_pin_code,
                        unit4_timer_clock_pin_code,
                        unit3_timer_clock_pin_code,
                        unit2_timer_clock_pin_code,
                        unit1_timer_clock_pin_code,
                        capture6_pin_code,
                        capture5_pin_code,
                        capture4_pin_code,
                        capture3_pin_code,
                        capture2_pin_code,
                        capture1_pin_code,
                        timer1_clock_pin_code,
                        ext_irq3_pin_code,
                        ext_irq2_pin_code,
                        ext_irq1_pin_code};

  // One registered pin picker per peripheral input
  genvar field;
  generate
    for (field = 0; field < `FIELD_COUNT; field = field + 1) begin : route
      remap_pin_select picker (
        .mclk         (mclk),
        .reset_n      (reset_n),
        .pin_code     (field_codes[field*`CODE_W +: `CODE_W]),
        .pin_level    (pin_sync),
        .routed_level (routed[field])
      );
    end
  endgenerate

  // Peripheral inputs in field order, index as in field_codes
  assign ext_irq1_in          = routed[0];
  assign ext_irq2_in          = routed[1];
  assign ext_irq3_in          = routed[2];
  assign timer1_clock_in      = routed[3];
  assign capture1_in          = routed[4];
  assign capture2_in          = routed[5];
  assign capture3_in          = routed[6];
  assign capture4_in          = routed[7];
  assign capture5_in          = routed[8];
  assign capture6_in          = routed[9];
  assign unit1_timer_clock_in = routed[10];
  assign unit2_timer_clock_in = routed[11];
  assign unit3_timer_clock_in = routed[12];
  assign unit4_timer_clock_in = routed[13];
  assign unit5_timer_clock_in = routed[14];
  assign unit6_timer_clock_in = routed[15];

endmodule // input_pin_remap_select

/* File: testbench/input_pin_remap_select_asserts.sv */
`timescale 1ns/100ps
`include "input_remap_map.vh"
module input_pin_remap_select_asserts (
  input wire        mclk,
  input wire        reset_n,
  input wire [3:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_write,
  input wire        reg_read,
  input wire [15:0] reg_rdata,
  input wire [31:0] remappable_pin,
  input wire        remap_lock,
  input wire        ext_irq1_in,
  input wire        ext_irq2_in,
  input wire        ext_irq3_in,
  input wire        timer1_clock_in,
  input wire        capture1_in,
  input wire        capture2_in,
  input wire        capture3_in,
  input wire        capture4_in,
  input wire        capture5_in,
  input wire        capture6_in,
  input wire        unit1_timer_clock_in,
  input wire        unit2_timer_clock_in,
  input wire        unit3_timer_clock_in,
  input wire        unit4_timer_clock_in,
  input wire        unit5_timer_clock_in,
  input wire        unit6_timer_clock_in
);
  wire [15:0] routed = {unit6_timer_clock_in, unit5_timer_clock_in, unit4_timer_clock_in, unit3_timer_clock_in,
                        unit2_timer_clock_in, unit1_timer_clock_in, capture6_in, capture5_in, capture4_in,
                        capture3_in, capture2_in, capture1_in, timer1_clock_in, ext_irq3_in, ext_irq2_in, ext_irq1_in};
  wire        wr_lock_bit = reg_wdata[`LOCK_BIT];
  wire        cfg_read = reg_read && reg_addr == `ADDR_LOCK_CONFIG;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  AST_RESET_CLEAR: assert property ($rose(reset_n) |-> !remap_lock && routed == 16'h0000)
    else $error("outputs not cleared by reset");
  AST_CFG_UNUSED_ZERO: assert property (cfg_read |=> reg_rdata[15:12] == 4'h0 && reg_rdata[10:0] == 11'h000)
    else $error("unused config bits not zero");
  AST_CFG_LOCK_BIT: assert property (cfg_read |=> reg_rdata[`LOCK_BIT] == $past(remap_lock))
    else $error("config read does not show lock");
  AST_HALF_SEL_LOW: assert property (reg_read && (reg_addr == `ADDR_EXT_IRQ1_SEL || reg_addr == `ADDR_TIMER1_CK_SEL)
                                     |=> reg_rdata[7:0] == 8'h00)
    else $error("unimplemented low byte not zero");
  AST_LOCK_NEEDS_WRITE: assert property ($changed(remap_lock) |-> $past(reg_write) && $past(reg_addr) == 4'h0)
    else $error("lock changed without config write");
  AST_LOCK_TAKES_DATA: assert property ($changed(remap_lock) |-> remap_lock == $past(wr_lock_bit))
    else $error("lock differs from written bit");
  AST_LOCKED_FREEZE: assert property ((remap_lock && $stable(remappable_pin))[*4] |-> $stable(routed))
    else $error("routed inputs moved while locked");
  AST_IDLE_FREEZE: assert property ((!reg_write && $stable(remappable_pin))[*4] |-> $stable(routed))
    else $error("routed inputs moved without cause");
  AST_WRITE_READBACK: assert property (reg_write && !remap_lock && reg_addr == `ADDR_EXT_IRQ2_3_SEL ##1
                                       reg_read && reg_addr == `ADDR_EXT_IRQ2_3_SEL |=>
                                       reg_rdata == $past(reg_wdata, 2))
    else $error("unlocked write not read back");

  cover property ($rose(remap_lock));
  cover property (remap_lock && reg_write && reg_addr == `ADDR_CAPTURE1_SEL);
  cover property (cfg_read ##1 reg_rdata[`LOCK_BIT]);
endmodule // input_pin_remap_select_asserts

/* File: testbench/input_pin_remap_select_tb.sv */
`timescale 1ns/100ps
`include "input_remap_map.vh"
module input_pin_remap_select_tb;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [31:0] remappable_pin = 32'h0000_0000;
  wire  [15:0] reg_rdata;
  wire         remap_lock;
  wire  [15:0] routed;
  logic [15:0] sel [1:9];
  int          errors = 0;
  int          n_checks = 0;

  always #2 mclk = ~mclk;

  input_pin_remap_select dut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .remappable_pin(remappable_pin),
    .remap_lock(remap_lock), .ext_irq1_in(routed[0]), .ext_irq2_in(routed[1]), .ext_irq3_in(routed[2]),
    .timer1_clock_in(routed[3]), .capture1_in(routed[4]), .capture2_in(routed[5]), .capture3_in(routed[6]),
    .capture4_in(routed[7]), .capture5_in(routed[8]), .capture6_in(routed[9]), .unit1_timer_clock_in(routed[10]),
    .unit2_timer_clock_in(routed[11]), .unit3_timer_clock_in(routed[12]), .unit4_timer_clock_in(routed[13]),
    .unit5_timer_clock_in(routed[14]), .unit6_timer_clock_in(routed[15]));

  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Strobes are set every cycle, so back-to-back calls never assign twice in a step
  task bus(input logic w, input logic r, input logic [3:0] ad, input logic [15:0] d);
    reg_write <= w;
    reg_read <= r;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge mclk);
    #1;
  endtask

  task rd(input logic [3:0] ad, input logic [15:0] exp, input string what);
    bus(1'b0, 1'b1, ad, 16'h0000);
    chk(what, exp, reg_rdata);
  endtask

  task put(input logic [3:0] ad, input logic [15:0] d);
    bus(1'b1, 1'b0, ad, d);
    sel[ad] = d;
  endtask

  task unlock(input logic [15:0] v);
    bus(1'b1, 1'b0, `ADDR_UNLOCK_KEY, `UNLOCK_KEY_FIRST);
    bus(1'b1, 1'b0, `ADDR_UNLOCK_KEY, `UNLOCK_KEY_SECOND);
    bus(1'b1, 1'b0, `ADDR_LOCK_CONFIG, v);
  endtask

  function automatic logic [15:0] mask(input int ad);
    mask = (ad == 1 || ad == 3) ? (sel[ad] & 16'hFF00) : sel[ad];
  endfunction

  function automatic logic [15:0] exp_route(input logic [31:0] p);
    logic [7:0] c;
    for (int f = 0; f < 16; f++) begin
      case (f)
        0: c = sel[1][15:8];
        1: c = sel[2][7:0];
        2: c = sel[2][15:8];
        3: c = sel[3][15:8];
        default: c = (f < 10) ? sel[f][15:8] : sel[f - 6][7:0];
      endcase
      exp_route[f] = (c >= 8'h01 && c <= 8'h20) ? p[c - 8'h01] : 1'b0;
    end
  endfunction

  // Two sync stages plus the pick register fit inside four edges
  task route(input logic [31:0] p);
    remappable_pin <= p;
    repeat (4) bus(1'b0, 1'b0, 4'h0, 16'h0000);
    chk("routed", exp_route(p), routed);
  endtask

  initial begin
    #100000;
    errors++;
    $display("mismatch watchdog expected 0 seen 1");
    end_sim;
  end

  initial begin
    for (int i = 1; i <= 9; i++)
      sel[i] = 16'h0000;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    #1;
    for (int i = 0; i <= 11; i++)
      rd(4'(i), 16'h0000, "reset value");
    chk("lock", 16'h0000, {15'h0000, remap_lock});
    chk("routed", 16'h0000, routed);
    $display("test reset done");
    bus(1'b1, 1'b0, `ADDR_LOCK_CONFIG, 16'hFFFF);
    rd(`ADDR_LOCK_CONFIG, 16'h0000, "config");
    rd(`ADDR_REMAP_STATUS, 16'h0002, "status");
    bus(1'b1, 1'b0, `ADDR_UNLOCK_KEY, `UNLOCK_KEY_FIRST);
    bus(1'b1, 1'b0, 4'hF, 16'hFFFF);
    bus(1'b1, 1'b0, `ADDR_UNLOCK_KEY, `UNLOCK_KEY_SECOND);
    bus(1'b1, 1'b0, `ADDR_LOCK_CONFIG, 16'hFFFF);
    chk("broken unlock", 16'h0000, {15'h0000, remap_lock});
    bus(1'b1, 1'b0, `ADDR_REMAP_STATUS, 16'h0002);
    rd(`ADDR_REMAP_STATUS, 16'h0000, "status clear");
    for (int i = 1; i <= 9; i++) begin
      put(4'(i), {8'(2 * i + 1), 8'(2 * i + 2)});
      rd(4'(i), mask(i), "selector");
    end
    route(32'hA5C3_0F96);
    route(32'h5A3C_F069);
    put(`ADDR_EXT_IRQ1_SEL, 16'h0000);
    put(`ADDR_EXT_IRQ2_3_SEL, 16'h21FF);
    put(`ADDR_TIMER1_CK_SEL, 16'h2000);
    route(32'hFFFF_FFFF);
    route(32'h8000_0001);
    $display("test selectors done");
    unlock(16'hFFFF);
    chk("lock", 16'h0001, {15'h0000, remap_lock});
    rd(`ADDR_LOCK_CONFIG, 16'h0800, "config");
    bus(1'b1, 1'b0, `ADDR_CAPTURE1_SEL, 16'h0101);
    bus(1'b1, 1'b0, `ADDR_EXT_IRQ2_3_SEL, 16'h0101);
    rd(`ADDR_CAPTURE1_SEL, mask(4), "locked selector");
    rd(`ADDR_EXT_IRQ2_3_SEL, mask(2), "locked selector");
    rd(`ADDR_REMAP_STATUS, 16'h0006, "status");
    route(32'h0000_FFFF);
    bus(1'b1, 1'b0, `ADDR_UNLOCK_KEY, `UNLOCK_KEY_FIRST);
    bus(1'b1, 1'b0, `ADDR_UNLOCK_KEY, `UNLOCK_KEY_SECOND);
    rd(`ADDR_REMAP_STATUS, 16'h0007, "armed status");
    bus(1'b1, 1'b0, `ADDR_LOCK_CONFIG, 16'h0000);
    chk("lock", 16'h0000, {15'h0000, remap_lock});
    put(`ADDR_CAPTURE1_SEL, 16'h0102);
    rd(`ADDR_CAPTURE1_SEL, mask(4), "selector");
    route(32'h0000_0003);
    bus(1'b1, 1'b0, 4'hF, 16'hFFFF);
    rd(4'hC, 16'h0000, "unmapped");
    rd(`ADDR_UNLOCK_KEY, 16'h0000, "key");
    $display("test lock done");
    unlock(16'h0800);
    chk("lock", 16'h0001, {15'h0000, remap_lock});
    reset_n <= 1'b0;
    repeat (2) bus(1'b0, 1'b0, 4'h0, 16'h0000);
    reset_n <= 1'b1;
    bus(1'b0, 1'b0, 4'h0, 16'h0000);
    for (int i = 0; i <= 9; i++)
      rd(4'(i), 16'h0000, "second reset");
    chk("lock", 16'h0000, {15'h0000, remap_lock});
    chk("routed", 16'h0000, routed);
    bus(1'b0, 1'b0, 4'h0, 16'h0000);
    $display("test second reset done");
    end_sim;
  end
endmodule // input_pin_remap_select_tb

bind input_pin_remap_select input_pin_remap_select_asserts assert_watch (.mclk(mclk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .remappable_pin(remappable_pin), .remap_lock(remap_lock), .ext_irq1_in(ext_irq1_in), .ext_irq2_in(ext_irq2_in),
  .ext_irq3_in(ext_irq3_in), .timer1_clock_in(timer1_clock_in), .capture1_in(capture1_in),
  .capture2_in(capture2_in), .capture3_in(capture3_in), .capture4_in(capture4_in), .capture5_in(capture5_in),
  .capture6_in(capture6_in), .unit1_timer_clock_in(unit1_timer_clock_in),
  .unit2_timer_clock_in(unit2_timer_clock_in), .unit3_timer_clock_in(unit3_timer_clock_in),
  .unit4_timer_clock_in(unit4_timer_clock_in), .unit5_timer_clock_in(unit5_timer_clock_in),
  .unit6_timer_clock_in(unit6_timer_clock_in));
